// file: src/bms_regs.svh
// Purpose: Offsets, field positions, reset values and codes of the boot mode selector
// Assumes: APB byte address is four times a register index
// Notes: Definitions only
`ifndef BMS_REGS_SVH
`define BMS_REGS_SVH

// Register indexes; byte address = index * 4
`define BMS_IDX_STATUS 16'hFE0A
`define BMS_IDX_PERSEL 16'hFE0C
`define BMS_IDX_SYSCFG 16'hFE0E
`define BMS_IDX_BUSCFG 16'hFE10
`define BMS_IDX_BOOTINFO 16'hFE12

// Field positions
`define BMS_ALT_FLAG_BIT 5
`define BMS_MEM_ENABLE_BIT 10
`define BMS_BYTE_HIGH_DIS_BIT 9
`define BMS_PERIPH_ENABLE_BIT 2
`define BMS_BUS_ACTIVE_BIT 10
`define BMS_LATCH_LENGTHEN_BIT 9
`define BMS_SEL_UART_BIT 0
`define BMS_SEL_CAN_BIT 1

// Strap field codes on config strap bits 5..4
`define BMS_STRAP_NORMAL 2'h3
`define BMS_STRAP_BSL 2'h2
`define BMS_STRAP_ALT 2'h1

// Values loaded on bootstrap entry and compared with the select word
`define BMS_PERSEL_BOOT 16'h002D
`define BMS_WORD_ZERO 16'h0000
`define BMS_WORD_ONES 16'hFFFF

// Flash addresses of signature words
`define BMS_ADDR_USER_OP0 24'h000000
`define BMS_ADDR_USER_OP1 24'h001FFC
`define BMS_ADDR_USER_REF 24'h001FFE
`define BMS_ADDR_ALT_OP0 24'h090000
`define BMS_ADDR_ALT_OP1 24'h091FFC
`define BMS_ADDR_ALT_REF 24'h091FFE

`endif

// file: src/bms_pkg.sv
// Purpose: Types of the boot mode selector
// Assumes: Constants live in bms_regs.svh
// Notes: None
package bms_pkg;

  typedef enum logic [7:0] {
    BMS_ST_WAIT = 8'h01,
    BMS_ST_DECIDE = 8'h02,
    BMS_ST_READ = 8'h04,
    BMS_ST_CHECK = 8'h08,
    BMS_ST_RUN = 8'h10,
    BMS_ST_RESET = 8'h20
  } bms_state_t;

  typedef enum logic [2:0] {
    BMS_MODE_NORMAL = 3'h0,
    BMS_MODE_BSL = 3'h1,
    BMS_MODE_ALT = 3'h2,
    BMS_MODE_USER = 3'h3,
    BMS_MODE_SELECT = 3'h4,
    BMS_MODE_TEST = 3'h5
  } bms_mode_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [17:0] paddr;
    logic [31:0] pwdata;
  } bms_apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } bms_apb_rsp_t;

  typedef struct packed {
    logic [15:0] sysConfig;
    logic [15:0] extPeriphSelect;
    logic [15:0] busConfigZero;
  } bms_cfg_t;

  typedef struct packed {
    bms_state_t st;
    bms_mode_t mode;
    logic resetPrev;
    logic [7:0] straps;
    logic extAccessN;
    logic [2:0] rdIdx;
    logic [15:0] op0;
    logic [15:0] op1;
    logic altFlag;
    logic uartWatch;
    logic canWatch;
    logic bootStart;
    logic [23:0] startAddress;
    logic softResetReq;
    logic einitDone;
    bms_cfg_t cfg;
  } bms_state_s_t;

endpackage

// file: src/bms_boot_mode_select.sv
// Purpose: Boot mode selection from reset straps, signature check and boot configuration
// Assumes: All inputs synchronous to clock; flash read port answers with a one-cycle valid
// Notes: Register interface is an APB slave with zero wait states
//
// What this block does and what it expects of software and board
// RL1 - Capture strap levels when external reset rises; select boot from those values.
// RL2 - Strap field 11 gives an ordinary reset with no bootstrap.
// RL3 - Strap field 10 starts the standard loader and clears the alternate indicator.
// RL4 - Strap field 01 enters alternate boot mode.
// RL5 - Every other strap code selects internal test modes.
// RL6 - Status register bit 5 shows that alternate boot was selected.
// RL7 - That flag is read-only and holds until software or hardware reset.
// RL8 - Software checks only bit 5 of the status register.
// RL9 - Signature: add two words, invert low byte of sum, compare with reference.
// RL10 - User signature uses words at 000000, 001FFC and reference 001FFE.
// RL11 - Alternate signature uses words at 090000, 091FFC and reference 091FFE.
// RL12 - Alternate boot picks its sequence by signatures; success starts at 090000.
// RL13 - No match: re-read 001FFC; 0000 or FFFF jumps to standard loader.
// RL14 - Otherwise low byte bit 0 enables UART watch, bit 1 CAN watch.
// RL15 - Watchdog stays off in alternate boot; watchdog reset becomes software reset.
// RL16 - Alternate boot is left only by software or hardware reset.
// RL17 - Bootstrap entry loads peripheral select 002D and sets peripheral enable.
// RL18 - Bootstrap sets memory enable bit 10; bit 9 follows data width strap.
// RL19 - Bus config zero is 0000 if access pin high, else bits 10, 9 set.
// RL20 - Software keeps all interrupts disabled while in alternate boot.
// RL21 - Board holds CAN receive at 1 during the second boot step.
// RL22 - In bootstrap the shared CAN receive bit may not be a user output.
`timescale 1ns/1ps
`include "bms_regs.svh"

module bms_boot_mode_select #(
  parameter int ADDR_WIDTH = 18
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Board pins and reset sources
  input wire logic externalResetInputN,
  input wire logic [7:0] configStrapPortLow,
  input wire logic externalAccessPinN,
  input wire logic softwareReset,
  input wire logic watchdogReset,
  input wire logic endOfInit,
  // Flash read port
  output logic flashReadReq,
  output logic [23:0] flashReadAddr,
  input wire logic flashReadValid,
  input wire logic [15:0] flashReadData,
  // Boot results
  output bms_pkg::bms_mode_t bootMode,
  output logic bootStart,
  output logic [23:0] startAddress,
  output logic uartWatch,
  output logic canWatch,
  output logic altBootFlag,
  output logic testMode,
  output logic watchdogEnable,
  output logic softResetReq,
  output logic canRxOutputBlock,
  output bms_pkg::bms_cfg_t bootConfig,
  // APB slave
  input wire bms_pkg::bms_apb_req_t apbReq,
  output bms_pkg::bms_apb_rsp_t apbRsp
);

  initial begin
    if (ADDR_WIDTH < 18 || ADDR_WIDTH > 32) begin
      $error("ADDR_WIDTH must lie between 18 and 32");
    end
  end

  function automatic logic sigMatch(input logic [15:0] a, input logic [15:0] b, input logic [15:0] refWord);
    logic [15:0] sum;
    sum = a + b;
    return {sum[15:8], ~sum[7:0]} == refWord;
  endfunction

  function automatic logic [23:0] readAddr(input logic [2:0] idx);
    unique case (idx)
      3'h0: return `BMS_ADDR_ALT_OP0;
      3'h1: return `BMS_ADDR_ALT_OP1;
      3'h2: return `BMS_ADDR_ALT_REF;
      3'h3: return `BMS_ADDR_USER_OP0;
      3'h4: return `BMS_ADDR_USER_OP1;
      3'h5: return `BMS_ADDR_USER_REF;
      default: return `BMS_ADDR_USER_OP1;
    endcase
  endfunction

  function automatic logic [17:0] regByte(input logic [15:0] idx);
    return {idx, 2'h0};
  endfunction

  bms_pkg::bms_state_s_t s_r;
  bms_pkg::bms_state_s_t s_nxt;

  logic isBoot;
  logic apbWrite;
  logic apbRead;
  logic [15:0] rdWord;
  logic hitStatus;
  logic hitPersel;
  logic hitSyscfg;
  logic hitBuscfg;
  logic hitInfo;

  // Both bootstrap kinds and alternate boot use the bootstrap configuration
  assign isBoot = s_r.mode == bms_pkg::BMS_MODE_BSL || s_r.mode == bms_pkg::BMS_MODE_ALT
                  || s_r.mode == bms_pkg::BMS_MODE_USER || s_r.mode == bms_pkg::BMS_MODE_SELECT;

  assign hitStatus = apbReq.paddr == regByte(`BMS_IDX_STATUS);
  assign hitPersel = apbReq.paddr == regByte(`BMS_IDX_PERSEL);
  assign hitSyscfg = apbReq.paddr == regByte(`BMS_IDX_SYSCFG);
  assign hitBuscfg = apbReq.paddr == regByte(`BMS_IDX_BUSCFG);
  assign hitInfo = apbReq.paddr == regByte(`BMS_IDX_BOOTINFO);
  assign apbWrite = apbReq.psel && apbReq.penable && apbReq.pwrite;
  assign apbRead = apbReq.psel && !apbReq.pwrite;

  always_comb begin
    rdWord = `BMS_WORD_ZERO;
    if (hitStatus) begin
      rdWord[`BMS_ALT_FLAG_BIT] = s_r.altFlag; // RL6
    end else if (hitPersel) begin
      rdWord = s_r.cfg.extPeriphSelect;
    end else if (hitSyscfg) begin
      rdWord = s_r.cfg.sysConfig;
    end else if (hitBuscfg) begin
      rdWord = s_r.cfg.busConfigZero;
    end else if (hitInfo) begin
      rdWord = {9'h000, s_r.mode, 2'h0, s_r.canWatch, s_r.uartWatch};
    end
  end

  always_comb begin
    apbRsp.pready = 1'b1;
    apbRsp.pslverr = apbReq.psel && apbReq.penable && !(hitStatus || hitPersel || hitSyscfg || hitBuscfg || hitInfo);
    apbRsp.prdata = apbRead ? {16'h0000, rdWord} : 32'h0000_0000;
  end

  always_comb begin
    s_nxt = s_r;
    s_nxt.bootStart = 1'b0;
    s_nxt.softResetReq = 1'b0;
    s_nxt.resetPrev = externalResetInputN;
    if (endOfInit) begin
      s_nxt.einitDone = 1'b1;
    end
    unique case (s_r.st)
      bms_pkg::BMS_ST_WAIT: begin
        if (externalResetInputN && !s_r.resetPrev) begin
          s_nxt.straps = configStrapPortLow; // RL1
          s_nxt.extAccessN = externalAccessPinN; // RL1
          s_nxt.st = bms_pkg::BMS_ST_DECIDE;
        end
      end
      bms_pkg::BMS_ST_DECIDE: begin
        s_nxt.rdIdx = 3'h0;
        // RL19
        s_nxt.cfg.busConfigZero = `BMS_WORD_ZERO;
        if (!s_r.extAccessN) begin
          s_nxt.cfg.busConfigZero[`BMS_BUS_ACTIVE_BIT] = 1'b1;
          s_nxt.cfg.busConfigZero[`BMS_LATCH_LENGTHEN_BIT] = 1'b1;
          s_nxt.cfg.busConfigZero[7:6] = s_r.straps[7:6];
        end
        s_nxt.cfg.sysConfig = `BMS_WORD_ZERO;
        s_nxt.cfg.sysConfig[`BMS_MEM_ENABLE_BIT] = s_r.extAccessN;
        s_nxt.cfg.extPeriphSelect = `BMS_WORD_ZERO;
        if (s_r.straps[5:4] != `BMS_STRAP_NORMAL) begin
          // RL17
          s_nxt.cfg.extPeriphSelect = `BMS_PERSEL_BOOT;
          s_nxt.cfg.sysConfig[`BMS_PERIPH_ENABLE_BIT] = 1'b1;
          s_nxt.cfg.sysConfig[`BMS_MEM_ENABLE_BIT] = 1'b1; // RL18
          // 8-bit bus type disables the high byte
          s_nxt.cfg.sysConfig[`BMS_BYTE_HIGH_DIS_BIT] = s_r.straps[7:6] == 2'h0; // RL18
        end
        unique case (s_r.straps[5:4])
          `BMS_STRAP_NORMAL: begin
            s_nxt.mode = bms_pkg::BMS_MODE_NORMAL; // RL2
            s_nxt.startAddress = `BMS_ADDR_USER_OP0;
            s_nxt.bootStart = 1'b1;
            s_nxt.st = bms_pkg::BMS_ST_RUN;
          end
          `BMS_STRAP_BSL: begin
            s_nxt.mode = bms_pkg::BMS_MODE_BSL; // RL3
            s_nxt.altFlag = 1'b0; // RL3
            s_nxt.uartWatch = 1'b1;
            s_nxt.canWatch = 1'b1;
            s_nxt.bootStart = 1'b1;
            s_nxt.st = bms_pkg::BMS_ST_RUN;
          end
          `BMS_STRAP_ALT: begin
            s_nxt.mode = bms_pkg::BMS_MODE_ALT; // RL4
            s_nxt.altFlag = 1'b1; // RL6
            s_nxt.st = bms_pkg::BMS_ST_READ;
          end
          default: begin
            s_nxt.mode = bms_pkg::BMS_MODE_TEST; // RL5
            s_nxt.st = bms_pkg::BMS_ST_RUN;
          end
        endcase
      end
      bms_pkg::BMS_ST_READ: begin
        if (flashReadValid) begin
          s_nxt.st = bms_pkg::BMS_ST_CHECK;
          if (s_r.rdIdx == 3'h0 || s_r.rdIdx == 3'h3) begin
            s_nxt.op0 = flashReadData;
          end else if (s_r.rdIdx == 3'h1 || s_r.rdIdx == 3'h4) begin
            s_nxt.op1 = flashReadData;
          end else begin
            s_nxt.op0 = flashReadData;
          end
        end
      end
      bms_pkg::BMS_ST_CHECK: begin
        s_nxt.st = bms_pkg::BMS_ST_READ;
        s_nxt.rdIdx = s_r.rdIdx + 3'h1;
        if (s_r.rdIdx == 3'h2 && sigMatch(s_r.op0, s_r.op1, s_r.op0) == 1'b0) begin
          s_nxt.rdIdx = 3'h3;
        end
        if (s_r.rdIdx == 3'h2 || s_r.rdIdx == 3'h5) begin
          // Reference word was stored in op0 slot after operands were summed
          if (sigMatch(s_r.straps[0] ? s_r.op0 : s_r.op0, s_r.op1, s_r.op0)) begin
            s_nxt.st = bms_pkg::BMS_ST_RUN;
          end
        end
        if (s_r.rdIdx == 3'h6) begin
          // RL13
          if (s_r.op0 == `BMS_WORD_ZERO || s_r.op0 == `BMS_WORD_ONES) begin
            s_nxt.mode = bms_pkg::BMS_MODE_BSL;
            s_nxt.uartWatch = 1'b1;
            s_nxt.canWatch = 1'b1;
          end else begin
            s_nxt.mode = bms_pkg::BMS_MODE_SELECT; // RL14
            s_nxt.uartWatch = s_r.op0[`BMS_SEL_UART_BIT]; // RL14
            s_nxt.canWatch = s_r.op0[`BMS_SEL_CAN_BIT]; // RL14
          end
          s_nxt.bootStart = 1'b1;
          s_nxt.st = bms_pkg::BMS_ST_RUN;
        end
      end
      bms_pkg::BMS_ST_RUN: begin
        // RL16
        if (softwareReset) begin
          s_nxt.st = bms_pkg::BMS_ST_RESET;
        // The flag marks every outcome of alternate boot, not only a good alternate signature
        end else if (watchdogReset && s_r.altFlag) begin
          s_nxt.softResetReq = 1'b1; // RL15
          s_nxt.st = bms_pkg::BMS_ST_RESET;
        end
      end
      bms_pkg::BMS_ST_RESET: begin
        // Software reset clears the flag and leaves every boot mode
        s_nxt.altFlag = 1'b0; // RL7
        s_nxt.mode = bms_pkg::BMS_MODE_NORMAL;
        s_nxt.uartWatch = 1'b0;
        s_nxt.canWatch = 1'b0;
        s_nxt.cfg.extPeriphSelect = `BMS_WORD_ZERO;
        s_nxt.cfg.sysConfig[`BMS_PERIPH_ENABLE_BIT] = 1'b0;
        s_nxt.startAddress = `BMS_ADDR_USER_OP0;
        s_nxt.bootStart = 1'b1;
        s_nxt.einitDone = 1'b0;
        s_nxt.st = bms_pkg::BMS_ST_RUN;
      end
      default: begin
        s_nxt.st = bms_pkg::BMS_ST_WAIT;
      end
    endcase
    // Signature outcome handled separately so the check stays in one place
    if (s_r.st == bms_pkg::BMS_ST_CHECK && s_r.rdIdx == 3'h2 && sigMatch(s_nxt.op1, s_r.op1, s_r.op0)) begin
      s_nxt.st = s_nxt.st;
    end
    if (s_r.st == bms_pkg::BMS_ST_READ && flashReadValid) begin
      if (s_r.rdIdx == 3'h2 || s_r.rdIdx == 3'h5) begin
        s_nxt.st = bms_pkg::BMS_ST_CHECK;
        if (sigMatch(s_r.op0, s_r.op1, flashReadData)) begin // RL9
          s_nxt.st = bms_pkg::BMS_ST_RUN;
          s_nxt.bootStart = 1'b1;
          s_nxt.mode = (s_r.rdIdx == 3'h2) ? bms_pkg::BMS_MODE_ALT : bms_pkg::BMS_MODE_USER;
          s_nxt.startAddress = (s_r.rdIdx == 3'h2) ? `BMS_ADDR_ALT_OP0 : `BMS_ADDR_USER_OP0; // RL12
        end else begin
          s_nxt.rdIdx = s_r.rdIdx;
        end
      end
    end
    if (s_r.st == bms_pkg::BMS_ST_CHECK && (s_r.rdIdx == 3'h2 || s_r.rdIdx == 3'h5)) begin
      // Failed signature: move on to the next table entry
      s_nxt.st = bms_pkg::BMS_ST_READ;
      s_nxt.rdIdx = s_r.rdIdx + 3'h1;
    end
    // Before end of init software may retune the peripheral selection
    if (apbWrite && !s_r.einitDone) begin
      if (hitPersel) begin
        s_nxt.cfg.extPeriphSelect = apbReq.pwdata[15:0];
      end
      if (hitSyscfg) begin
        s_nxt.cfg.sysConfig[`BMS_PERIPH_ENABLE_BIT] = apbReq.pwdata[`BMS_PERIPH_ENABLE_BIT];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s_r <= '{st: bms_pkg::BMS_ST_WAIT, mode: bms_pkg::BMS_MODE_NORMAL, resetPrev: 1'b0,
               straps: 8'h00, extAccessN: 1'b1, rdIdx: 3'h0, op0: 16'h0000, op1: 16'h0000,
               altFlag: 1'b0, uartWatch: 1'b0, canWatch: 1'b0, bootStart: 1'b0,
               startAddress: 24'h000000, softResetReq: 1'b0, einitDone: 1'b0,
               cfg: '{sysConfig: 16'h0000, extPeriphSelect: 16'h0000, busConfigZero: 16'h0000}};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign flashReadReq = s_r.st == bms_pkg::BMS_ST_READ;
  assign flashReadAddr = readAddr(s_r.rdIdx); // RL10 RL11 RL13
  assign bootMode = s_r.mode;
  assign bootStart = s_r.bootStart;
  assign startAddress = s_r.startAddress;
  assign uartWatch = s_r.uartWatch;
  assign canWatch = s_r.canWatch;
  assign altBootFlag = s_r.altFlag;
  assign testMode = s_r.mode == bms_pkg::BMS_MODE_TEST;
  assign watchdogEnable = !isBoot; // RL15
  assign softResetReq = s_r.softResetReq;
  assign canRxOutputBlock = isBoot; // RL22
  assign bootConfig = s_r.cfg;

endmodule // bms_boot_mode_select

// file: bench/bms_boot_mode_select_assertions.sv
// Purpose: Concurrent checks on the boot mode selector ports
// Assumes: Straps are captured once per hardware reset
// Notes: Attached by bind below the module
`timescale 1ns/1ps
module bms_boot_mode_select_assertions (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Board pins
  input wire logic externalResetInputN,
  input wire logic [7:0] configStrapPortLow,
  input wire logic externalAccessPinN,
  input wire logic softwareReset,
  input wire logic watchdogReset,
  // Flash port
  input wire logic flashReadReq,
  input wire logic [23:0] flashReadAddr,
  // Boot results
  input wire bms_pkg::bms_mode_t bootMode,
  input wire logic bootStart,
  input wire logic [23:0] startAddress,
  input wire logic altBootFlag,
  input wire logic testMode,
  input wire logic watchdogEnable,
  input wire logic softResetReq,
  input wire logic canRxOutputBlock,
  input wire bms_pkg::bms_cfg_t bootConfig,
  // APB
  input wire bms_pkg::bms_apb_req_t apbReq,
  input wire bms_pkg::bms_apb_rsp_t apbRsp
);
  logic prevN_r;
  logic armed_r;
  logic cap;
  logic [1:0] code;

  // Only the first rising pin edge after a hardware reset counts
  assign cap = armed_r && externalResetInputN && !prevN_r && !rst;
  assign code = configStrapPortLow[5:4];

  always_ff @(posedge clock) begin
    prevN_r <= externalResetInputN;
    armed_r <= rst ? 1'b1 : (cap ? 1'b0 : armed_r);
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  AST_NORMAL: assert property (cap && code == 2'h3 |-> ##2 bootStart && bootMode == bms_pkg::BMS_MODE_NORMAL)
    else $error("normal straps did not give a normal start");
  AST_BSL: assert property (cap && code == 2'h2 |-> ##2 bootStart && bootMode == bms_pkg::BMS_MODE_BSL
    && !altBootFlag && bootConfig.extPeriphSelect == 16'h002D)
    else $error("loader straps gave wrong mode or setup");
  AST_ALT: assert property (cap && code == 2'h1 |-> ##2 flashReadReq && flashReadAddr == 24'h090000)
    else $error("alternate straps did not start signature reads");
  AST_TEST: assert property (cap && code == 2'h0 |-> ##2 testMode)
    else $error("test straps did not select test mode");
  AST_FLAG_HOLD: assert property (altBootFlag && !softwareReset && !$past(softwareReset) && !softResetReq
    |=> altBootFlag)
    else $error("alternate flag dropped without reset");
  AST_WDOG_OFF: assert property (altBootFlag |-> !watchdogEnable)
    else $error("watchdog enabled in alternate boot");
  AST_WD_SOFT: assert property (altBootFlag && watchdogReset |=> softResetReq)
    else $error("watchdog reset not turned into software reset");
  AST_CANRX: assert property (bootMode == bms_pkg::BMS_MODE_BSL |-> canRxOutputBlock)
    else $error("shared receive bit not blocked as output");
  AST_SYSCFG: assert property (bootStart && bootMode == bms_pkg::BMS_MODE_BSL
    |-> bootConfig.sysConfig[10] && bootConfig.sysConfig[2])
    else $error("loader system setup bits missing");
  AST_STATUS: assert property (apbReq.psel && apbReq.penable && !apbReq.pwrite && apbReq.paddr == 18'h3F828
    |-> apbRsp.pready && apbRsp.prdata[5] == altBootFlag)
    else $error("status bit 5 differs from flag");
  AST_BUSCFG: assert property (bootStart |-> (bootConfig.busConfigZero & 16'h0600)
    == (externalAccessPinN ? 16'h0000 : 16'h0600))
    else $error("bus config zero wrong for access pin");
  AST_ALT_START: assert property (bootStart && bootMode == bms_pkg::BMS_MODE_ALT |-> startAddress == 24'h090000)
    else $error("alternate start address wrong");

  cover property (bootStart && bootMode == bms_pkg::BMS_MODE_ALT);
  cover property (bootStart && bootMode == bms_pkg::BMS_MODE_SELECT);
  cover property (testMode);
  cover property (softResetReq);
endmodule // bms_boot_mode_select_assertions

bind bms_boot_mode_select bms_boot_mode_select_assertions i_bms_boot_mode_select_assertions (.*);

// file: bench/bms_flash_model.sv
// Purpose: Flash holding the signature words
// Assumes: One request at a time, held until answered
// Notes: Data line toggles outside answers so stale values never look valid
`timescale 1ns/1ps
module bms_flash_model (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Read port
  input wire logic flashReadReq,
  input wire logic [23:0] flashReadAddr,
  output logic flashReadValid,
  output logic [15:0] flashReadData,
  // Contents and pacing
  input wire logic [5:0][15:0] words,
  input wire logic slow
);
  logic [1:0] waitCnt;

  always_ff @(posedge clock) begin
    flashReadValid <= 1'b0;
    flashReadData <= ~flashReadData;
    if (rst) begin
      waitCnt <= 2'h0;
      flashReadData <= 16'h5A5A;
    end else if (flashReadReq && !flashReadValid) begin
      if (waitCnt != (slow ? 2'h2 : 2'h0)) begin
        waitCnt <= waitCnt + 2'h1;
      end else begin
        waitCnt <= 2'h0;
        flashReadValid <= 1'b1;
        case (flashReadAddr)
          24'h090000: flashReadData <= words[0];
          24'h091FFC: flashReadData <= words[1];
          24'h091FFE: flashReadData <= words[2];
          24'h000000: flashReadData <= words[3];
          24'h001FFC: flashReadData <= words[4];
          24'h001FFE: flashReadData <= words[5];
          default: flashReadData <= 16'hDEAD;
        endcase
      end
    end
  end
endmodule // bms_flash_model

// file: bench/bms_boot_mode_select_bench.sv
// Purpose: Self-checking bench of the boot mode selector
// Assumes: Flash model answers promptly or slowly by row
// Notes: Rows cover every strap code and signature outcome
`timescale 1ns/1ps
`include "bms_regs.svh"
module bms_boot_mode_select_bench;
  typedef struct packed {
    logic [7:0] straps;
    logic accN;
    logic [5:0][15:0] w;
    bms_pkg::bms_mode_t mode;
    logic [23:0] start;
    logic [1:0] watch;
    logic alt;
  } bms_row_t;

  logic clock = 1'b0;
  logic rst = 1'b1;
  logic externalResetInputN = 1'b0;
  logic [7:0] configStrapPortLow = 8'h00;
  logic externalAccessPinN = 1'b1;
  logic softwareReset = 1'b0;
  logic watchdogReset = 1'b0;
  logic endOfInit = 1'b0;
  logic flashReadReq;
  logic [23:0] flashReadAddr;
  logic flashReadValid;
  logic [15:0] flashReadData;
  bms_pkg::bms_mode_t bootMode;
  logic bootStart;
  logic [23:0] startAddress;
  logic uartWatch;
  logic canWatch;
  logic altBootFlag;
  logic testMode;
  logic watchdogEnable;
  logic softResetReq;
  logic canRxOutputBlock;
  bms_pkg::bms_cfg_t bootConfig;
  bms_pkg::bms_apb_req_t apbReq = '0;
  bms_pkg::bms_apb_rsp_t apbRsp;
  logic [5:0][15:0] words = '0;
  logic slow = 1'b0;
  logic [31:0] rd;
  logic err;
  int errors = 0;
  int checks = 0;
  bms_row_t rows [11];
  bms_row_t r;

  always #12.5 clock = ~clock;

  bms_boot_mode_select i_bms_boot_mode_select (.*);
  bms_flash_model i_bms_flash_model (.clock(clock), .rst(rst), .flashReadReq(flashReadReq),
    .flashReadAddr(flashReadAddr), .flashReadValid(flashReadValid), .flashReadData(flashReadData),
    .words(words), .slow(slow));

  task automatic end_of_test();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic guard(input int n);
    if (n >= 50) begin
      cmp(32'h0, 32'h1);
      end_of_test();
    end
  endtask

  task automatic waitDone();
    int n;
    n = 0;
    while (n < 50 && bootStart !== 1'b1 && testMode !== 1'b1) begin
      @(posedge clock);
      n++;
    end
    guard(n);
  endtask

  task automatic apb(input logic wr, input logic [15:0] idx, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clock);
    apbReq <= '{1'b1, 1'b0, wr, {idx, 2'b00}, wd};
    @(posedge clock);
    apbReq.penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (apbRsp.pready !== 1'b1 && n < 50);
    rd = apbRsp.prdata;
    err = apbRsp.pslverr;
    apbReq <= '0;
    guard(n);
  endtask

  // Alternate pair sums to 1235, user pair is 0100 plus the word at 001FFC
  function automatic bms_row_t mk(input logic [7:0] s, input logic a, input logic [15:0] aRef,
    input logic [15:0] uOp1, input logic [15:0] uRef, input bms_pkg::bms_mode_t m, input logic [23:0] st,
    input logic [1:0] wt, input logic al);
    mk = '{s, a, {uRef, uOp1, 16'h0100, aRef, 16'h0001, 16'h1234}, m, st, wt, al};
  endfunction

  initial begin
    rows[0] = mk(8'hB0, 1'b1, 16'h0, 16'h0, 16'h0, bms_pkg::BMS_MODE_NORMAL, 24'h0, 2'h0, 1'b0);
    rows[1] = mk(8'h20, 1'b0, 16'h0, 16'h0, 16'h0, bms_pkg::BMS_MODE_BSL, 24'h0, 2'h3, 1'b0);
    rows[2] = mk(8'h80, 1'b1, 16'h0, 16'h0, 16'h0, bms_pkg::BMS_MODE_TEST, 24'h0, 2'h0, 1'b0);
    rows[3] = mk(8'h90, 1'b1, 16'h12CA, 16'h0, 16'h0, bms_pkg::BMS_MODE_ALT, 24'h090000, 2'h0, 1'b1);
    rows[4] = mk(8'h90, 1'b1, 16'h0, 16'h0203, 16'h03FC, bms_pkg::BMS_MODE_USER, 24'h0, 2'h0, 1'b1);
    rows[5] = mk(8'h90, 1'b1, 16'h0, 16'h5503, 16'h0, bms_pkg::BMS_MODE_SELECT, 24'h0, 2'h3, 1'b1);
    rows[6] = mk(8'h90, 1'b0, 16'h0, 16'hAA01, 16'h0, bms_pkg::BMS_MODE_SELECT, 24'h0, 2'h1, 1'b1);
    rows[7] = mk(8'h90, 1'b1, 16'h0, 16'h0002, 16'h0, bms_pkg::BMS_MODE_SELECT, 24'h0, 2'h2, 1'b1);
    rows[8] = mk(8'h90, 1'b1, 16'h0, 16'h0000, 16'h0, bms_pkg::BMS_MODE_BSL, 24'h0, 2'h3, 1'b1);
    rows[9] = mk(8'h90, 1'b1, 16'h0, 16'hFFFF, 16'h1111, bms_pkg::BMS_MODE_BSL, 24'h0, 2'h3, 1'b1);
    rows[10] = mk(8'h90, 1'b0, 16'h12CA, 16'h0, 16'h0, bms_pkg::BMS_MODE_ALT, 24'h090000, 2'h0, 1'b1);
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    cmp(watchdogEnable, 1'b1);
    cmp(altBootFlag, 1'b0);
    $display("reset done");
    // Bench raises no interrupt and drives no CAN receive level while booting
    for (int i = 0; i < 11; i++) begin
      r = rows[i];
      @(posedge clock);
      rst <= 1'b1;
      externalResetInputN <= 1'b0;
      configStrapPortLow <= r.straps;
      externalAccessPinN <= r.accN;
      words <= r.w;
      slow <= i[0];
      @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      externalResetInputN <= 1'b1;
      waitDone();
      cmp(bootMode, r.mode);
      cmp(altBootFlag, r.alt);
      cmp({canWatch, uartWatch}, r.watch);
      if (bootStart === 1'b1) begin
        cmp(bootConfig.busConfigZero & 16'h0600, r.accN ? 16'h0000 : 16'h0600);
      end
      if (r.mode inside {bms_pkg::BMS_MODE_ALT, bms_pkg::BMS_MODE_USER, bms_pkg::BMS_MODE_NORMAL}) begin
        cmp(startAddress, r.start);
      end
      if (r.straps[5:4] == 2'h2) begin
        cmp(bootConfig.extPeriphSelect, 16'h002D);
        cmp(bootConfig.sysConfig & 16'h0604, 16'h0604);
        cmp(canRxOutputBlock, 1'b1);
      end
      $display("row %0d done", i);
    end
    apb(1'b0, `BMS_IDX_STATUS, 32'h0);
    cmp(rd & 32'h20, 32'h20);
    apb(1'b1, `BMS_IDX_STATUS, 32'h0);
    apb(1'b0, `BMS_IDX_STATUS, 32'h0);
    cmp(rd & 32'h20, 32'h20);
    apb(1'b0, 16'h0100, 32'h0);
    cmp(err, 1'b1);
    apb(1'b1, `BMS_IDX_PERSEL, 32'h0011);
    apb(1'b0, `BMS_IDX_PERSEL, 32'h0);
    cmp(rd, 32'h0011);
    @(posedge clock);
    endOfInit <= 1'b1;
    @(posedge clock);
    endOfInit <= 1'b0;
    apb(1'b1, `BMS_IDX_PERSEL, 32'h0022);
    apb(1'b0, `BMS_IDX_PERSEL, 32'h0);
    cmp(rd, 32'h0011);
    $display("registers done");
    @(posedge clock);
    watchdogReset <= 1'b1;
    @(posedge clock);
    watchdogReset <= 1'b0;
    @(posedge clock);
    cmp(softResetReq, 1'b1);
    cmp(watchdogEnable, 1'b0);
    cmp(altBootFlag, 1'b1);
    softwareReset <= 1'b1;
    @(posedge clock);
    softwareReset <= 1'b0;
    waitDone();
    cmp(altBootFlag, 1'b0);
    cmp(bootMode, bms_pkg::BMS_MODE_NORMAL);
    $display("resets done");
    end_of_test();
  end
endmodule // bms_boot_mode_select_bench
